// ### hdl/ext_shift_defs.svh
`ifndef EXT_SHIFT_DEFS_SVH
`define EXT_SHIFT_DEFS_SVH

// data path width and shift amount width
`define XS_WIDTH          32
`define XS_AMT_W          5

// primary and extended opcodes of the served instructions
`define XS_PRIMARY_OP     6'd31
`define XS_XOP_SHL_EXT    10'd153
`define XS_XOP_SHR_EXT    10'd665
`define XS_XOP_SHL_AUX    10'd217
`define XS_XOP_SHR_AUX    10'd729
`define XS_XOP_SRA_IMM    10'd824
`define XS_XOP_SRA_REG    10'd792
`define XS_XOP_SRA_IMM_Q  10'd952
`define XS_XOP_SRA_REG_Q  10'd920

// instruction field positions (bit 0 = msb numbering mapped to [31:0])
`define XS_PRIM_HI        31
`define XS_PRIM_LO        26
`define XS_DEST_HI        20
`define XS_DEST_LO        16
`define XS_IMM_HI         15
`define XS_IMM_LO         11
`define XS_XOP_HI         10
`define XS_XOP_LO         1
`define XS_REC_BIT        0

// amount register fields: amount bits 27..31, mask-off bit 26
`define XS_AMT_HI         4
`define XS_AMT_LO         0
`define XS_AMT_OFF_BIT    5

// sign bit (bit 0 in msb numbering)
`define XS_SIGN_BIT       31

// reset values
`define XS_MQ_RST         32'h0000_0000
`define XS_CA_RST         1'b0
`define XS_CR0_RST        4'h0

`endif

// ### hdl/ext_shift_pkg.sv
`include "ext_shift_defs.svh"

package ext_shift_pkg;

	// served operations
	typedef enum logic [3:0] {
		OP_NONE,
		OP_SHL_EXT,
		OP_SHR_EXT,
		OP_SHL_AUX,
		OP_SHR_AUX,
		OP_SRA_IMM,
		OP_SRA_REG,
		OP_SRA_IMM_Q,
		OP_SRA_REG_Q
	} shift_op_e;

	// condition field 0 bits, order less, greater, zero, summary overflow
	typedef struct packed {
		logic less_flag;
		logic greater_flag;
		logic zero_flag;
		logic overflow_summary_flag;
	} cr_field_s;

	// issued instruction with its operands
	typedef struct packed {
		logic [`XS_WIDTH-1:0] instr;
		logic [`XS_WIDTH-1:0] source_register;
		logic [`XS_WIDTH-1:0] amount_register;
	} issue_s;

	// write back to the register file
	typedef struct packed {
		logic [4:0]           dest_index;
		logic [`XS_WIDTH-1:0] dest_register;
	} writeback_s;

endpackage : ext_shift_pkg

// ### hdl/rotate_mask.sv
`timescale 1ns/1ps
`default_nettype none
`include "ext_shift_defs.svh"

module rotate_mask #(
	parameter int WIDTH = `XS_WIDTH,
	parameter int AMT_W = `XS_AMT_W
) (
	input  wire logic [WIDTH-1:0] word,
	input  wire logic [AMT_W-1:0] amount,
	input  wire logic             rot_right,
	input  wire logic             mask_off,
	output logic      [WIDTH-1:0] rotated,
	output logic      [WIDTH-1:0] mask
);

	// doubled word lets a plain shift act as a rotate
	wire [2*WIDTH-1:0] dbl_word  = {word, word};
	wire [2*WIDTH-1:0] dbl_left  = dbl_word << amount;
	wire [2*WIDTH-1:0] dbl_right = dbl_word >> amount;
	wire [WIDTH-1:0]   all_ones  = {WIDTH{1'b1}};

	// left by n, or left by width-n which equals right by n
	assign rotated = rot_right ? dbl_right[WIDTH-1:0] : dbl_left[2*WIDTH-1:WIDTH];

	// left: ones then n zeros; right: n zeros then ones; off: all zero
	assign mask = mask_off  ? {WIDTH{1'b0}} :
	              rot_right ? (all_ones >> amount) : (all_ones << amount);

endmodule : rotate_mask
`default_nettype wire

// ### hdl/ext_shift_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "ext_shift_defs.svh"

module ext_shift_unit (
	input  wire logic                    clk,
	input  wire logic                    sys_rst,
	input  wire logic                    issue_valid,
	input  wire ext_shift_pkg::issue_s   issue,
	input  wire logic                    summary_overflow,
	input  wire logic                    mq_load_valid,
	input  wire logic [`XS_WIDTH-1:0]    mq_load_value,
	output logic                         result_valid,
	output ext_shift_pkg::writeback_s    writeback,
	output logic                         cr_write,
	output ext_shift_pkg::cr_field_s     condition_flags,
	output logic                         ca_write,
	output logic                         shift_out_flag,
	output logic                         mq_write,
	output logic [`XS_WIDTH-1:0]         multiply_quotient_reg,
	output logic                         unsupported
);
	import ext_shift_pkg::*;

	localparam int W = `XS_WIDTH;

	// instruction fields
	wire [5:0]             prim_op    = issue.instr[`XS_PRIM_HI:`XS_PRIM_LO];
	wire [9:0]             ext_op     = issue.instr[`XS_XOP_HI:`XS_XOP_LO];
	wire [4:0]             dest_idx   = issue.instr[`XS_DEST_HI:`XS_DEST_LO];
	wire [`XS_AMT_W-1:0]   imm_amount = issue.instr[`XS_IMM_HI:`XS_IMM_LO];
	wire                   record_flag = issue.instr[`XS_REC_BIT];
	wire                   prim_ok    = (prim_op == `XS_PRIMARY_OP);

	// register amount field and its mask-off bit
	wire [`XS_AMT_W-1:0]   reg_amount = issue.amount_register[`XS_AMT_HI:`XS_AMT_LO];
	wire                   amt_off    = issue.amount_register[`XS_AMT_OFF_BIT];

	// source sign bit
	wire                   sign_bit   = issue.source_register[`XS_SIGN_BIT];

	// opcode decode
	shift_op_e op;
	assign op = !prim_ok                       ? OP_NONE      :
	            (ext_op == `XS_XOP_SHL_EXT)    ? OP_SHL_EXT   :
	            (ext_op == `XS_XOP_SHR_EXT)    ? OP_SHR_EXT   :
	            (ext_op == `XS_XOP_SHL_AUX)    ? OP_SHL_AUX   :
	            (ext_op == `XS_XOP_SHR_AUX)    ? OP_SHR_AUX   :
	            (ext_op == `XS_XOP_SRA_IMM)    ? OP_SRA_IMM   :
	            (ext_op == `XS_XOP_SRA_REG)    ? OP_SRA_REG   :
	            (ext_op == `XS_XOP_SRA_IMM_Q)  ? OP_SRA_IMM_Q :
	            (ext_op == `XS_XOP_SRA_REG_Q)  ? OP_SRA_REG_Q : OP_NONE;

	// operation properties
	wire is_left   = (op == OP_SHL_EXT) || (op == OP_SHL_AUX);
	wire is_imm    = (op == OP_SRA_IMM) || (op == OP_SRA_IMM_Q);
	wire is_alg_rg = (op == OP_SRA_REG) || (op == OP_SRA_REG_Q);
	wire is_alg    = is_imm || is_alg_rg;
	wire mq_merge  = (op == OP_SHL_AUX) || (op == OP_SHR_AUX);
	wire is_and    = (op == OP_SHL_EXT) || (op == OP_SHR_EXT);

	// aux register load: extended, extended-with-aux and the q algebraic forms
	wire loads_mq  = is_and || mq_merge
	               || (op == OP_SRA_IMM_Q) || (op == OP_SRA_REG_Q);

	// carry register write; srai computes but keeps the register
	wire writes_ca = (op == OP_SRA_REG) || (op == OP_SRA_IMM_Q)
	               || (op == OP_SRA_REG_Q);

	// amount source: immediate forms use the instruction field
	wire [`XS_AMT_W-1:0] shift_n = is_imm ? imm_amount : reg_amount;

	// bit 26 only matters for the register algebraic forms
	wire mask_off = is_alg_rg && amt_off;

	// rotator and mask generator
	logic [W-1:0] rotated;
	logic [W-1:0] mask;

	rotate_mask #(
		.WIDTH (W),
		.AMT_W (`XS_AMT_W)
	) u_rotate_mask (
		.word      (issue.source_register),
		.amount    (shift_n),
		.rot_right (!is_left),
		.mask_off  (mask_off),
		.rotated   (rotated),
		.mask      (mask)
	);

	// word merged in where the mask is zero
	wire [W-1:0] sign_word  = {W{sign_bit}};
	wire [W-1:0] fill_word  = is_alg   ? sign_word             :
	                          mq_merge ? multiply_quotient_reg :
	                                     {W{1'b0}};

	// mask one takes rotated bit, mask zero takes fill bit
	wire [W-1:0] merged     = (rotated & mask) | (fill_word & ~mask);

	// carry out of the algebraic shift
	wire         carry_calc = (|(rotated & ~mask)) & sign_bit;

	// signed compare of the result against zero
	wire         res_neg    = merged[W-1];
	wire         res_zero   = (merged == {W{1'b0}});
	cr_field_s   cr_calc;
	assign cr_calc.less_flag             = res_neg;
	assign cr_calc.greater_flag          = !res_neg && !res_zero;
	assign cr_calc.zero_flag             = res_zero;
	assign cr_calc.overflow_summary_flag = summary_overflow;

	// accepted instruction strobes
	wire take     = issue_valid && (op != OP_NONE);
	wire take_bad = issue_valid && (op == OP_NONE);
	wire take_rec = take && record_flag;
	wire take_mq  = take && loads_mq;
	wire take_ca  = take && writes_ca;

	// next values; a served instruction that loads the aux wins over an outside aux load
	writeback_s  wb_nxt;
	assign wb_nxt.dest_index    = dest_idx;
	assign wb_nxt.dest_register = merged;

	wire [W-1:0] mq_nxt = take_mq       ? rotated       :
	                      mq_load_valid ? mq_load_value :
	                                      multiply_quotient_reg;
	wire mq_wr_nxt = take_mq || mq_load_valid;

	wire         ca_nxt = take_ca ? carry_calc : shift_out_flag;
	cr_field_s   cr_nxt;
	assign cr_nxt = take_rec ? cr_calc : condition_flags;

	// write-back strobe and result word
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			result_valid <= 1'b0;
			writeback    <= '0;
		end
		else
		begin
			result_valid <= take;
			// hold the last result when idle
			if (take)
			begin
				writeback <= wb_nxt;
			end
		end
	end

	// aux quotient register and its write strobe
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			multiply_quotient_reg <= `XS_MQ_RST;
			mq_write              <= 1'b0;
		end
		else
		begin
			multiply_quotient_reg <= mq_nxt;
			mq_write              <= mq_wr_nxt;
		end
	end

	// carry bit of the exception register
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			shift_out_flag <= `XS_CA_RST;
			ca_write       <= 1'b0;
		end
		else
		begin
			shift_out_flag <= ca_nxt;
			ca_write       <= take_ca;
		end
	end

	// condition field zero
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			condition_flags <= `XS_CR0_RST;
			cr_write        <= 1'b0;
		end
		else
		begin
			condition_flags <= cr_nxt;
			cr_write        <= take_rec;
		end
	end

	// opcode this unit does not serve
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			unsupported <= 1'b0;
		end
		else
		begin
			unsupported <= take_bad;
		end
	end

endmodule : ext_shift_unit
`default_nettype wire

// ### verif/reg_file_model.sv
`timescale 1ns/1ps
`default_nettype none
module reg_file_model (
	input wire logic                       clk,
	input wire logic                       result_valid,
	input wire ext_shift_pkg::writeback_s  writeback
);
	import ext_shift_pkg::*;
	// register file, one word per index
	logic [31:0] regs [32];
	// capture every result the unit hands back
	always_ff @(posedge clk)
		if (result_valid)
			regs[writeback.dest_index] <= writeback.dest_register;
endmodule : reg_file_model
`default_nettype wire

// ### verif/ext_shift_unit_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "ext_shift_defs.svh"
module ext_shift_unit_sva (
	input wire logic                       clk,
	input wire logic                       sys_rst,
	input wire logic                       issue_valid,
	input wire ext_shift_pkg::issue_s      issue,
	input wire logic                       summary_overflow,
	input wire logic                       mq_load_valid,
	input wire logic [`XS_WIDTH-1:0]       mq_load_value,
	input wire logic                       result_valid,
	input wire ext_shift_pkg::writeback_s  writeback,
	input wire logic                       cr_write,
	input wire ext_shift_pkg::cr_field_s   condition_flags,
	input wire logic                       ca_write,
	input wire logic                       shift_out_flag,
	input wire logic                       mq_write,
	input wire logic [`XS_WIDTH-1:0]       multiply_quotient_reg,
	input wire logic                       unsupported
);
	import ext_shift_pkg::*;
	// extended opcode and its classes
	wire logic [9:0] xop = issue.instr[`XS_XOP_HI:`XS_XOP_LO];
	wire logic       srv;
	wire logic       ca_op;
	wire logic       no_mq;
	assign srv = issue.instr[`XS_PRIM_HI:`XS_PRIM_LO] == `XS_PRIMARY_OP
		&& (xop inside {10'd153, 10'd665, 10'd217, 10'd729, 10'd824, 10'd792, 10'd952, 10'd920});
	assign ca_op = xop inside {10'd792, 10'd952, 10'd920};
	assign no_mq = xop inside {10'd792, 10'd824};
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_result_after_issue: assert property (issue_valid && srv |=> result_valid && !unsupported)
		else $error("served instruction gave no result");
	a_refuse_unknown: assert property (issue_valid && !srv |=> unsupported && !result_valid && !cr_write)
		else $error("unknown opcode not refused");
	a_carry_write_ops: assert property (issue_valid && srv |=> ca_write == $past(ca_op))
		else $error("carry write on wrong opcode");
	a_sra_keeps_aux: assert property (issue_valid && srv && no_mq && !mq_load_valid |=> !mq_write)
		else $error("aux changed by plain algebraic shift");
	a_record_strobe: assert property (issue_valid && srv |=> cr_write == $past(issue.instr[0]))
		else $error("record strobe mismatch");
	a_aux_hold: assert property (!mq_write |-> $stable(multiply_quotient_reg))
		else $error("aux changed without strobe");
	a_carry_hold: assert property (!ca_write |-> $stable(shift_out_flag))
		else $error("carry changed without strobe");
	a_flags_compare: assert property (cr_write |-> condition_flags.less_flag == writeback.dest_register[31]
		&& condition_flags.zero_flag == (writeback.dest_register == 32'h0))
		else $error("condition flags disagree with result");
	a_summary_copy: assert property (issue_valid && srv && issue.instr[0]
		|=> condition_flags.overflow_summary_flag == $past(summary_overflow))
		else $error("summary overflow not copied");
endmodule : ext_shift_unit_sva
bind ext_shift_unit ext_shift_unit_sva chk (.clk, .sys_rst, .issue_valid, .issue,
	.summary_overflow, .mq_load_valid, .mq_load_value, .result_valid, .writeback, .cr_write,
	.condition_flags, .ca_write, .shift_out_flag, .mq_write, .multiply_quotient_reg, .unsupported);
`default_nettype wire

// ### verif/tb_ext_shift_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ext_shift_unit;
	import ext_shift_pkg::*;
	logic        clk, sys_rst, issue_valid, summary_overflow, mq_load_valid, ca_e;
	logic        result_valid, cr_write, ca_write, shift_out_flag, mq_write, unsupported;
	logic [31:0] mq_load_value, multiply_quotient_reg, mq_e, wb_e;
	issue_s      issue;
	writeback_s  writeback;
	cr_field_s   condition_flags, cr_e;
	int          errors, checks;
	// eight served opcodes and one that is not served
	logic [9:0]  ops [9] = '{153, 665, 217, 729, 824, 792, 952, 920, 152};
	// amounts: zero, plain, maximum, mask-off bit set
	logic [31:0] amts [4] = '{32'h0, 32'h4, 32'h1f, 32'h23};
	logic [31:0] srcs [2] = '{32'h8000_0001, 32'h7f00_ff01};
	ext_shift_unit dut (.clk, .sys_rst, .issue_valid, .issue, .summary_overflow,
		.mq_load_valid, .mq_load_value, .result_valid, .writeback, .cr_write,
		.condition_flags, .ca_write, .shift_out_flag, .mq_write, .multiply_quotient_reg,
		.unsupported);
	reg_file_model rf (.clk, .result_valid, .writeback);
	// free running clock
	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			errors++;
		end
	endtask : chk
	task give_verdict;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	// reset pulse, then all state back to zero
	task reset_dut;
		sys_rst = 1;
		repeat (2) @(posedge clk);
		#1 sys_rst = 0;
		{mq_e, wb_e, ca_e, cr_e} = '0;
		chk("reset", 0, writeback | multiply_quotient_reg | {condition_flags, shift_out_flag});
	endtask : reset_dut
	// outside write to the aux register
	task mq_load(input logic [31:0] v);
		mq_load_valid = 1;
		mq_load_value = v;
		@(posedge clk) #1 mq_load_valid = 0;
		mq_e = v;
		chk("mq load", v, multiply_quotient_reg);
		chk("mq load strobe", 1, mq_write);
	endtask : mq_load
	// issue one instruction and compare every output
	task do_op(input logic [9:0] x, input logic [31:0] s, input logic [31:0] a, input logic r);
		logic [4:0]  n, im;
		logic [31:0] rot, m, f, res;
		logic        lf, sup, c;
		sup = x != 10'd152;
		im = a[4:0] + 5'd1;
		n = (x == 824 || x == 952) ? im : a[4:0];
		lf = x == 153 || x == 217;
		rot = lf ? s << n | s >> (32 - n) : s >> n | s << (32 - n);
		m = lf ? 32'hffff_ffff << n : 32'hffff_ffff >> n;
		if ((x == 792 || x == 920) && a[5])
			m = 0;
		f = x >= 792 ? {32{s[31]}} : (x == 217 || x == 729) ? mq_e : 0;
		res = rot & m | f & ~m;
		c = |(rot & ~m) & s[31];
		issue_valid = 1;
		issue = '{{6'd31, 5'd0, x[4:0], im, x, r}, s, a};
		summary_overflow = s[0];
		@(posedge clk) #1 issue_valid = 0;
		if (sup)
		begin
			wb_e = res;
			if (x != 792 && x != 824)
				mq_e = rot;
			if (x == 792 || x == 920 || x == 952)
				ca_e = c;
			if (r)
				cr_e = '{res[31], !res[31] && res != 0, res == 0, s[0]};
		end
		chk("valid", sup, result_valid);
		chk("unsupported", !sup, unsupported);
		chk("result", wb_e, writeback.dest_register);
		chk("aux", mq_e, multiply_quotient_reg);
		chk("carry", ca_e, shift_out_flag);
		chk("flags", cr_e, condition_flags);
		chk("flag strobe", sup && r, cr_write);
		chk("aux strobe", sup && x != 792 && x != 824, mq_write);
		chk("carry strobe", x == 792 || x == 920 || x == 952, ca_write);
		@(posedge clk) #1;
		if (sup)
			chk("regfile", res, rf.regs[x[4:0]]);
	endtask : do_op
	// main sequence
	initial
	begin
		{issue_valid, summary_overflow, mq_load_valid, mq_load_value} = '0;
		issue = '0;
		{errors, checks} = '0;
		reset_dut();
		mq_load(32'hdead_beef);
		foreach (ops[i])
			foreach (amts[j])
				foreach (srcs[k])
					do_op(ops[i], srcs[k], amts[j], j[0] ^ k[0]);
		reset_dut();
		give_verdict();
	end
endmodule : tb_ext_shift_unit
`default_nettype wire
